// file: core/phs_map.vh
// How it works
// - 16-bit data, six address lines, active-low strobes
// - addresses 32-63 global, 0-31 paged
// - global 33 is page selector
// - addresses 0-31 reach current page
// - globals reached directly without paging
// - write captured when store strobe rises
// - 2-pin mode: select strobes, store gives direction
// - unmasked raised flag drives interrupt output
// - reading source register clears flag and interrupt
// - each function selects its own sync source
// - four sync pins sampled on rising edge
// - codes: pins, counter, one-shot, off, on
// - common selectors drive common function syncs
// - channel selectors drive channel oscillator syncs
`ifndef PHS_MAP_VH
`define PHS_MAP_VH
// ==========================================================
// address map (word addresses on the six address lines)
`define PHS_GLOBAL_BIT      5
`define PHS_A_STATUS        6'h20
`define PHS_A_PAGE          6'h21
`define PHS_A_ONESHOT       6'h22
`define PHS_A_CNT_PERIOD    6'h23
`define PHS_A_SSEL_COM0     6'h24
`define PHS_A_SSEL_COM1     6'h25
`define PHS_A_SSEL_CHAN     6'h26
`define PHS_A_IRQ_FLAG0     6'h27
`define PHS_A_IRQ_FLAG1     6'h28
`define PHS_A_IRQ_FLAG2     6'h29
`define PHS_A_IRQ_MASK      6'h2a
`define PHS_A_MODE          6'h2b
`define PHS_A_SRC0          6'h30
// ==========================================================
// fields and constants
`define PHS_NUM_COM         7
`define PHS_NUM_CHAN        4
`define PHS_NUM_SSEL        11
`define PHS_NUM_IRQ         16
`define PHS_SS_ONESHOT      3'h5
`define PHS_SS_OFF          3'h6
`define PHS_SS_ON           3'h7
`define PHS_SS_RESET        3'h6
`define PHS_PAGE_RESET      16'h0000
`define PHS_CNT_RESET       16'hffff
`define PHS_MASK_RESET      16'hffff
`define PHS_MODE_RESET      16'h0000
`define PHS_MODE_TWO_PIN    0
`endif

// file: core/phs_sync_select.v
`timescale 1ns/100ps
`default_nettype none
`include "phs_map.vh"
// ==========================================================
// one sync selector: picks a source from an eight-way code
module phs_sync_select (
  // source vector, one bit per code
  input  wire [7:0] src_in,
  // selection code
  input  wire [2:0] code_in,
  // selected sync
  output wire       sync_out
);
  // plain mux; sources are already registered upstream
  assign sync_out = src_in[code_in];
endmodule // phs_sync_select
`default_nettype wire

// file: core/phs_host_port.v
`timescale 1ns/100ps
`default_nettype none
`include "phs_map.vh"
// ==========================================================
// paged host port with sync source selection
module phs_host_port (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        sys_rst_in,
  // host bus
  input  wire [5:0]  addr_in,
  input  wire        cs_n_in,
  input  wire        rd_n_in,
  input  wire        wr_n_in,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output wire        data_oe_n_out,
  output wire        irq_out,
  // paged register space, served outside
  output reg  [15:0] page_out,
  output wire [4:0]  paged_addr_out,
  output reg         paged_wr_out,
  output wire [15:0] paged_wdata_out,
  input  wire [15:0] paged_rdata_in,
  // interrupt sources
  input  wire [15:0] irq_set_in,
  input  wire [15:0] irq_src_data_in,
  // sync pins
  input  wire        sync_input_a_in,
  input  wire        sync_input_b_in,
  input  wire        sync_input_c_in,
  input  wire        sync_input_d_in,
  // selected syncs: common 0..6, channel 7..10
  output wire [10:0] sync_out
);
  // ========================================================
  // registers
  reg  [15:0] page_reg;        // current page
  reg  [2:0]  ssel_reg [0:10]; // per-function sync codes
  reg  [15:0] cnt_period_reg;  // sync counter period
  reg  [15:0] cnt_reg;         // sync counter value
  reg         cnt_tc_reg;      // terminal count pulse
  reg         oneshot_reg;     // one-shot pulse
  reg  [15:0] irq_flag_reg;    // sticky source flags
  reg  [15:0] irq_mask_reg;    // one = masked
  reg  [15:0] mode_reg;        // bit0 two-pin mode
  reg  [3:0]  pin_reg;         // sampled sync pins
  reg         wr_act_reg;      // store active last cycle
  reg         rd_act_reg;      // read active last cycle
  reg  [5:0]  addr_reg;        // address held across strobe
  reg  [15:0] wdata_reg;       // data held across strobe
  reg  [15:0] rdata_next;      // read mux
  integer     i;               // selector reset loop
  integer     j;               // flag loop, kept apart from i
  wire        two_pin  = mode_reg[`PHS_MODE_TWO_PIN];
  // ========================================================
  // strobe decode; two-pin: select is strobe, store picks way
  wire        wr_act   = two_pin ? (!cs_n_in && !wr_n_in)
                                 : (!cs_n_in && !wr_n_in);
  wire        rd_act   = two_pin ? (!cs_n_in && wr_n_in)
                                 : (!cs_n_in && !rd_n_in);
  // write lands on the strobe's rising edge
  wire        wr_done  = wr_act_reg && !wr_act;
  wire        rd_done  = rd_act_reg && !rd_act;
  wire        is_global = addr_reg[`PHS_GLOBAL_BIT];
  // ========================================================
  // bus drive only during reads
  assign data_oe_n_out   = !rd_act;
  assign irq_out         = |(irq_flag_reg & ~irq_mask_reg);
  assign paged_addr_out  = addr_reg[4:0];
  assign paged_wdata_out = wdata_reg;
  // ========================================================
  // read mux over globals and the current page
  always @* begin
    rdata_next = 16'h0000;
    if (!addr_in[`PHS_GLOBAL_BIT]) begin
      rdata_next = paged_rdata_in;
    end else begin
      case (addr_in)
        `PHS_A_STATUS:     rdata_next = {11'h000, pin_reg, irq_out};
        `PHS_A_PAGE:       rdata_next = page_reg;
        `PHS_A_CNT_PERIOD: rdata_next = cnt_period_reg;
        `PHS_A_SSEL_COM0:  rdata_next = {1'b0, ssel_reg[3], 1'b0, ssel_reg[2],
                                         1'b0, ssel_reg[1], 1'b0, ssel_reg[0]};
        `PHS_A_SSEL_COM1:  rdata_next = {4'h0, 1'b0, ssel_reg[6],
                                         1'b0, ssel_reg[5], 1'b0, ssel_reg[4]};
        `PHS_A_SSEL_CHAN:  rdata_next = {1'b0, ssel_reg[10], 1'b0, ssel_reg[9],
                                         1'b0, ssel_reg[8], 1'b0, ssel_reg[7]};
        `PHS_A_IRQ_FLAG0:  rdata_next = {12'h000, irq_flag_reg[3:0]};
        `PHS_A_IRQ_FLAG1:  rdata_next = {12'h000, irq_flag_reg[7:4]};
        `PHS_A_IRQ_FLAG2:  rdata_next = {8'h00, irq_flag_reg[15:8]};
        `PHS_A_IRQ_MASK:   rdata_next = irq_mask_reg;
        `PHS_A_MODE:       rdata_next = mode_reg;
        default: begin
          if (addr_in[5:4] == 2'h3) begin
            rdata_next = {15'h0000, irq_src_data_in[addr_in[3:0]]};
          end else begin
            rdata_next = 16'h0000;
          end
        end
      endcase
    end
  end
  // ========================================================
  // host side sequencing and global register writes
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      page_reg       <= `PHS_PAGE_RESET;
      page_out       <= `PHS_PAGE_RESET;
      cnt_period_reg <= `PHS_CNT_RESET;
      irq_mask_reg   <= `PHS_MASK_RESET;
      mode_reg       <= `PHS_MODE_RESET;
      oneshot_reg    <= 1'b0;
      wr_act_reg     <= 1'b0;
      rd_act_reg     <= 1'b0;
      addr_reg       <= 6'h00;
      wdata_reg      <= 16'h0000;
      data_out       <= 16'h0000;
      paged_wr_out   <= 1'b0;
      pin_reg        <= 4'h0;
      for (i = 0; i < `PHS_NUM_SSEL; i = i + 1) begin
        ssel_reg[i] <= `PHS_SS_RESET;
      end
    end else begin
      wr_act_reg   <= wr_act;
      rd_act_reg   <= rd_act;
      oneshot_reg  <= 1'b0;
      paged_wr_out <= 1'b0;
      page_out     <= page_reg;
      // pins sampled on the rising edge before use
      pin_reg <= {sync_input_d_in, sync_input_c_in,
                  sync_input_b_in, sync_input_a_in};
      // hold address and data while the strobe is low
      if (wr_act || rd_act) begin
        addr_reg  <= addr_in;
        wdata_reg <= data_in;
      end
      if (rd_act) begin
        data_out <= rdata_next;
      end
      if (wr_done && !is_global) begin
        paged_wr_out <= 1'b1;
      end
      if (wr_done && is_global) begin
        case (addr_reg)
          `PHS_A_PAGE:       page_reg <= wdata_reg;
          `PHS_A_ONESHOT:    oneshot_reg <= wdata_reg[0];
          `PHS_A_CNT_PERIOD: cnt_period_reg <= wdata_reg;
          `PHS_A_SSEL_COM0: begin
            ssel_reg[0] <= wdata_reg[2:0];
            ssel_reg[1] <= wdata_reg[6:4];
            ssel_reg[2] <= wdata_reg[10:8];
            ssel_reg[3] <= wdata_reg[14:12];
          end
          `PHS_A_SSEL_COM1: begin
            ssel_reg[4] <= wdata_reg[2:0];
            ssel_reg[5] <= wdata_reg[6:4];
            ssel_reg[6] <= wdata_reg[10:8];
          end
          `PHS_A_SSEL_CHAN: begin
            ssel_reg[7]  <= wdata_reg[2:0];
            ssel_reg[8]  <= wdata_reg[6:4];
            ssel_reg[9]  <= wdata_reg[10:8];
            ssel_reg[10] <= wdata_reg[14:12];
          end
          `PHS_A_IRQ_MASK:   irq_mask_reg <= wdata_reg;
          `PHS_A_MODE:       mode_reg <= wdata_reg;
          default:           ;
        endcase
      end
    end
  end
  // ========================================================
  // sticky flags; a new set beats the read clear
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_flag_reg <= 16'h0000;
    end else begin
      for (j = 0; j < `PHS_NUM_IRQ; j = j + 1) begin
        if (irq_set_in[j]) begin
          irq_flag_reg[j] <= 1'b1;
        end else if (rd_done && addr_reg == (`PHS_A_SRC0 + j[5:0])) begin
          irq_flag_reg[j] <= 1'b0;
        end
      end
    end
  end
  // ========================================================
  // common sync counter, terminal count pulses once a period
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_reg    <= 16'h0000;
      cnt_tc_reg <= 1'b0;
    end else if (cnt_reg >= cnt_period_reg) begin
      cnt_reg    <= 16'h0000;
      cnt_tc_reg <= 1'b1;
    end else begin
      cnt_reg    <= cnt_reg + 16'h0001;
      cnt_tc_reg <= 1'b0;
    end
  end
  // ========================================================
  // one selector per function
  wire [7:0] sync_src = {1'b1, 1'b0, oneshot_reg, cnt_tc_reg, pin_reg};
  genvar g;
  generate
    for (g = 0; g < `PHS_NUM_SSEL; g = g + 1) begin : g_sel
      phs_sync_select u_sel (
        .src_in   (sync_src),
        .code_in  (ssel_reg[g]),
        .sync_out (sync_out[g])
      );
    end
  endgenerate
endmodule // phs_host_port
`default_nettype wire

// file: testbench/phs_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// pin-level protocol checker
module phs_checker (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  // host bus
  input wire logic [5:0]  addr_in,
  input wire logic        cs_n_in,
  input wire logic        rd_n_in,
  input wire logic        wr_n_in,
  input wire logic [15:0] data_in,
  input wire logic        data_oe_n_out,
  input wire logic        irq_out,
  // internal views
  input wire logic [15:0] page_out,
  input wire logic        paged_wr_out,
  input wire logic [10:0] sync_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] wd;  // data seen as a store ends
  always_ff @(posedge clk_sys_in)
    if ($rose(wr_n_in)) wd <= data_in;
  a_bus_release: assert property (!data_oe_n_out |-> !cs_n_in)
    else $error("bus driven while unselected");
  a_read_drive: assert property (!cs_n_in && !rd_n_in && wr_n_in |-> !data_oe_n_out)
    else $error("bus not driven during read");
  a_write_quiet: assert property (!wr_n_in |-> data_oe_n_out)
    else $error("bus driven during store");
  a_paged_store: assert property ($rose(wr_n_in) && !cs_n_in && !addr_in[5]
    |-> ##[1:3] paged_wr_out)
    else $error("paged store missing");
  a_global_store: assert property ($rose(wr_n_in) && !cs_n_in && addr_in[5]
    |-> ##1 !paged_wr_out [*3])
    else $error("global store leaked to page");
  a_page_take: assert property ($rose(wr_n_in) && !cs_n_in && addr_in == 6'h21
    |-> ##[1:3] page_out == wd)
    else $error("page selector not taken");
  a_reset_quiet: assert property ($fell(sys_rst_in) |-> sync_out == 11'h000 && !irq_out)
    else $error("outputs active after reset");
  a_irq_hold: assert property (irq_out && cs_n_in && $past(cs_n_in) |=> irq_out)
    else $error("interrupt dropped without read");
endmodule // phs_checker
bind phs_host_port phs_checker i_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .addr_in(addr_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
  .data_in(data_in), .data_oe_n_out(data_oe_n_out), .irq_out(irq_out),
  .page_out(page_out), .paged_wr_out(paged_wr_out), .sync_out(sync_out));
`default_nettype wire

// file: testbench/phs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// host processor model, strobes move just after edges
module phs_host_model (
  input wire logic         clk_in,
  output logic [5:0]       addr_out,
  output logic             cs_n_out,
  output wire logic        rd_n_out,
  output logic             wr_n_out,
  output logic [15:0]      data_out,
  output logic             done_out
);
  logic two_pin = 1'b0;  // strobe on select, direction on store line
  logic rd_q = 1'b1;
  assign rd_n_out = two_pin ? 1'b0 : rd_q;
  initial begin
    addr_out = 6'h00; cs_n_out = 1'b1; wr_n_out = 1'b1; data_out = 16'h0000; done_out = 1'b0;
  end
  // address, select, data, then store pulse; two-pin: address, data, store low, then select pulse
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_in) begin
      addr_out <= a;
      data_out <= d;
      if (two_pin) wr_n_out <= 1'b0; else cs_n_out <= 1'b0;
    end
    @(posedge clk_in) if (two_pin) cs_n_out <= 1'b0; else wr_n_out <= 1'b0;
    @(posedge clk_in) if (two_pin) cs_n_out <= 1'b1; else wr_n_out <= 1'b1;
    @(posedge clk_in) begin cs_n_out <= 1'b1; wr_n_out <= 1'b1; data_out <= ~data_out; end
  endtask
  // strobe held two edges, flags read by caller after interrupt
  task rd(input logic [5:0] a);
    @(posedge clk_in) begin addr_out <= a; cs_n_out <= 1'b0; rd_q <= 1'b0; end
    @(posedge clk_in);
    @(posedge clk_in) begin cs_n_out <= 1'b1; rd_q <= 1'b1; done_out <= 1'b1; end
    @(posedge clk_in) done_out <= 1'b0;
  endtask
endmodule // phs_host_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench top
module tb;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, cs_n, wr_n, rd_n, oe_n, irq, pwr, done;
  logic [5:0] addr;
  logic [4:0] paddr;
  logic [15:0] wdata, rdata, page, pwdata, prdata, irq_set = 16'h0, src = 16'h0, r0, r1;
  logic [15:0] pmem [0:127];  // two bits of page times 32 words
  logic [3:0] pins = 4'h0;
  logic [10:0] sync;
  logic probe = 1'b0;
  int psel = 0, pulses = 0, num_errors = 0, compares = 0;
  logic [15:0] exp_q[$];  // expected results, oldest first
  initial forever #10 clk_sys_in = ~clk_sys_in;
  phs_host_model i_host (.clk_in(clk_sys_in), .addr_out(addr), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .data_out(wdata), .done_out(done));
  phs_host_port i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .data_in(wdata), .data_out(rdata),
    .data_oe_n_out(oe_n), .irq_out(irq), .page_out(page), .paged_addr_out(paddr),
    .paged_wr_out(pwr), .paged_wdata_out(pwdata), .paged_rdata_in(prdata),
    .irq_set_in(irq_set), .irq_src_data_in(src), .sync_input_a_in(pins[0]),
    .sync_input_b_in(pins[1]), .sync_input_c_in(pins[2]), .sync_input_d_in(pins[3]),
    .sync_out(sync));
  // paged store outside the port
  assign prdata = pmem[{page[1:0], paddr}];
  always @(posedge clk_sys_in) begin
    if (pwr) pmem[{page[1:0], paddr}] <= pwdata;
    if (sync[7]) pulses <= pulses + 1;
  end
  task check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // monitor takes the oldest note when a result appears
  always @(posedge clk_sys_in) if (done || probe)
    check(done ? rdata : psel == 0 ? {15'h0, sync[0]} : psel == 1 ? {15'h0, irq}
          : pulses[15:0], exp_q.pop_front());
  task rx(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e); i_host.rd(a);
  endtask
  task chk(input int s, input logic [15:0] e);
    exp_q.push_back(e); psel = s;
    @(posedge clk_sys_in) probe <= 1'b1;
    @(posedge clk_sys_in) probe <= 1'b0;
  endtask
  task results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles needed
  initial begin repeat (20000) @(posedge clk_sys_in); num_errors++; results(); end
  initial begin
    void'($urandom(32'he5a3));
    r0 = 16'($urandom); r1 = 16'($urandom);
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    // paged words on two pages
    i_host.wr(6'h21, 16'h0001); i_host.wr(6'h03, r0);
    i_host.wr(6'h21, 16'h0002); i_host.wr(6'h03, r1);
    rx(6'h21, 16'h0002);
    i_host.wr(6'h21, 16'h0001); rx(6'h03, r0);
    i_host.wr(6'h21, 16'h0002); rx(6'h03, r1);
    i_host.wr(6'h3f, r0); rx(6'h3f, 16'h0000);
    // sync codes on common selector zero
    pins <= 4'($urandom);
    for (int c = 0; c < 8; c++) if (c != 4 && c != 5) begin
      i_host.wr(6'h24, c[15:0]); repeat (3) @(posedge clk_sys_in);
      chk(0, c < 4 ? {15'h0, pins[c]} : {15'h0, c == 7});
    end
    i_host.wr(6'h26, 16'h6665); i_host.wr(6'h22, 16'h0001);
    repeat (4) @(posedge clk_sys_in); chk(2, 16'h0001);
    // terminal count: counter runs zero to period, so one pulse per four clocks
    i_host.wr(6'h23, 16'h0003); i_host.wr(6'h26, 16'h6664);
    repeat (39) @(posedge clk_sys_in); chk(2, 16'h000b);
    // unmasked flag, then clear by reading its source
    i_host.wr(6'h2a, 16'hfffe);
    @(posedge clk_sys_in) irq_set <= 16'h0001;
    @(posedge clk_sys_in) begin irq_set <= 16'h0000; src <= r1; end
    repeat (2) @(posedge clk_sys_in); chk(1, 16'h0001);
    rx(6'h27, 16'h0001); rx(6'h28, 16'h0000); rx(6'h29, 16'h0000);
    // a source register reads back its own source bit only
    rx(6'h30, {15'h0000, r1[0]}); chk(1, 16'h0000);
    rx(6'h27, 16'h0000);
    // select strobes, store line gives direction
    i_host.wr(6'h2b, 16'h0001); i_host.two_pin <= 1'b1;
    i_host.wr(6'h21, r0); rx(6'h21, r0);
    repeat (3) @(posedge clk_sys_in);
    results();
  end
endmodule // tb
`default_nettype wire
